// ==== pkg/eeprom_regs.svh ====
// named constants for the serial eeprom command controller
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

// opcodes, sent msb first
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_STATUS_READ 8'h05
`define CMD_STATUS_WRITE 8'h01
`define CMD_MEM_READ 8'h03
`define CMD_MEM_WRITE 8'h02
// ident page read and lock state read share one code
`define CMD_IDENT_PAGE_READ 8'h83
// ident page write and page lock share one code
`define CMD_IDENT_PAGE_WRITE 8'h82

// status byte bit positions
`define SR_WRITE_DISABLE 7
`define SR_BLOCK_HI 3
`define SR_BLOCK_LO 2
`define SR_WEL 1
`define SR_WIP 0

// block protect codes and range bases
`define BP_NONE 2'h0
`define BP_QUARTER 2'h1
`define BP_HALF 2'h2
`define BP_ALL 2'h3
`define BASE_QUARTER 17'h18000
`define BASE_HALF 17'h10000

// serial framing
`define BIT_LAST 3'h7
`define ADDR_LAST 2'h2

// write cycle timing
`define WRITE_TIME_US 5000
`define CLOCK_MHZ 100
`define TIMER_W 19

// avalon register byte offsets
`define REG_STATUS 4'h0
`define REG_CTRL 4'h4
`define REG_LAST 4'h8
`define REG_WRITTEN 4'hc

// reset value of the pin synchroniser {pick_n, pause_n, protect_n, sck, mosi}
`define PIN_IDLE 5'h1c

`endif

// ==== pkg/eeprom_pkg.sv ====
// types shared by the serial eeprom command controller
package eeprom_pkg;
    typedef enum logic [4:0] {
        PH_OPCODE = 5'h01,
        PH_ADDR = 5'h02,
        PH_DATA = 5'h04,
        PH_READOUT = 5'h08,
        PH_WAIT = 5'h10
    } phase_t;
endpackage

// ==== hw/pin_sync.sv ====
// two-stage synchroniser for the serial pins
`timescale 1ns/1ns
`include "eeprom_regs.svh"
module pin_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] pins,
    output logic [4:0] synced
);
    logic [4:0] stage1;
    logic [4:0] next_stage1;
    logic [4:0] next_synced;

    // first stage feeds only the second
    always_comb begin
        next_stage1 = pins;
        next_synced = stage1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= `PIN_IDLE;
            synced <= `PIN_IDLE;
        end else begin
            stage1 <= next_stage1;
            synced <= next_synced;
        end
    end
endmodule // pin_sync

// ==== hw/eeprom_cmd_ctrl.sv ====
// serial eeprom command decode, protection and protocol control
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "eeprom_regs.svh"
module eeprom_cmd_ctrl
    import eeprom_pkg::*;
#(
    parameter int WRITE_CYCLE_CYCLES = `WRITE_TIME_US * `CLOCK_MHZ
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic PICK_N,
    input wire logic SCK,
    input wire logic MOSI,
    input wire logic PAUSE_N,
    input wire logic PROTECT_PIN_N,
    output logic MISO_LINE,
    output logic MISO_LINE_OE,
    output logic STANDBY,
    input wire logic [3:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST
);
    logic [4:0] synced;
    logic cs_n, hold_n, wp_n, sck, mosi;
    logic cs_d, hold_d, sck_d;

    // serial state
    logic sel, armed, paused, started, have_data, unknown;
    phase_t phase;
    logic [2:0] bit_cnt;
    logic [1:0] addr_cnt;
    logic [7:0] shift_in, opcode, data0, out_sh;
    logic [23:0] addr;
    // status and write cycle state
    logic write_enable_latch, write_in_progress, wdis, pend_sr;
    logic [1:0] bp, pend_bp;
    logic pend_wdis;
    logic [`TIMER_W-1:0] timer;
    logic [7:0] last_op;
    logic last_exec, last_rej, last_prot;
    logic [16:0] waddr;
    logic [7:0] wdata;
    // software control
    logic ident_en;
    logic [7:0] read_fill;

    logic next_sel, next_armed, next_paused, next_started, next_have_data, next_unknown;
    phase_t next_phase;
    logic [2:0] next_bit_cnt;
    logic [1:0] next_addr_cnt;
    logic [7:0] next_shift_in, next_opcode, next_data0, next_out_sh;
    logic [23:0] next_addr;
    logic next_wel, next_wip, next_wdis, next_pend_sr, next_pend_wdis;
    logic [1:0] next_bp, next_pend_bp;
    logic [`TIMER_W-1:0] next_timer;
    logic [7:0] next_last_op;
    logic next_last_exec, next_last_rej, next_last_prot;
    logic [16:0] next_waddr;
    logic [7:0] next_wdata;
    logic next_miso, next_miso_oe, next_standby;

    logic sck_rise, sck_fall, hold_fall, hold_rise;
    logic [7:0] byte_in, status_byte;
    logic aligned, is_read, hw_locked, in_protected;

    pin_sync u_sync (
        .clk(CLOCK),
        .rst_n(RSTN),
        .pins({PICK_N, PAUSE_N, PROTECT_PIN_N, SCK, MOSI}),
        .synced(synced)
    );

    assign {cs_n, hold_n, wp_n, sck, mosi} = synced;
    // status byte layout
    assign status_byte = {wdis, 3'h0, bp, write_enable_latch, write_in_progress};
    assign byte_in = {shift_in[6:0], mosi}; // msb first
    assign aligned = (bit_cnt == 3'h0);
    assign hw_locked = wdis & ~wp_n;
    assign is_read = (opcode == `CMD_MEM_READ) || (ident_en && opcode == `CMD_IDENT_PAGE_READ);

    // protected range check on the captured address
    always_comb begin
        unique case (bp)
            `BP_NONE: in_protected = 1'b0;
            `BP_QUARTER: in_protected = (addr[16:0] >= `BASE_QUARTER);
            `BP_HALF: in_protected = (addr[16:0] >= `BASE_HALF);
            `BP_ALL: in_protected = 1'b1;
        endcase
    end

    // edges seen by the system clock; clock and data dropped while paused
    always_comb begin
        sck_rise = sck & ~sck_d & sel & ~paused;
        sck_fall = ~sck & sck_d & sel & ~paused;
        hold_fall = hold_d & ~hold_n;
        hold_rise = ~hold_d & hold_n;
    end

    // serial protocol next state
    always_comb begin
        next_sel = sel;
        next_armed = armed;
        next_paused = paused;
        next_started = started;
        next_have_data = have_data;
        next_unknown = unknown;
        next_phase = phase;
        next_bit_cnt = bit_cnt;
        next_addr_cnt = addr_cnt;
        next_shift_in = shift_in;
        next_opcode = opcode;
        next_data0 = data0;
        next_out_sh = out_sh;
        next_addr = addr;
        next_wel = write_enable_latch;
        next_wip = write_in_progress;
        next_wdis = wdis;
        next_bp = bp;
        next_pend_sr = pend_sr;
        next_pend_bp = pend_bp;
        next_pend_wdis = pend_wdis;
        next_timer = timer;
        next_last_op = last_op;
        next_last_exec = last_exec;
        next_last_rej = last_rej;
        next_last_prot = last_prot;
        next_waddr = waddr;
        next_wdata = wdata;
        next_miso = MISO_LINE;

        // self-timed write cycle; latch clears on completion
        if (write_in_progress) begin
            next_timer = timer - `TIMER_W'(1);
            if (timer == `TIMER_W'(1)) begin
                next_wip = 1'b0;
                next_wel = 1'b0;
                if (pend_sr) begin
                    next_bp = pend_bp;
                    next_wdis = pend_wdis;
                    next_pend_sr = 1'b0;
                end
            end
        end

        if (!sel) begin
            // first selection needs a falling edge after power-up
            if (cs_n) begin
                next_armed = 1'b1;
            end else if (cs_d && armed) begin
                next_sel = 1'b1;
            end
        end else if (cs_n) begin
            // deselect: run the command only if framed on a byte edge
            next_last_op = opcode;
            next_last_exec = 1'b0;
            next_last_rej = 1'b0;
            next_last_prot = 1'b0;
            if (phase == PH_DATA && have_data && aligned && opcode == `CMD_MEM_WRITE) begin
                if (!write_enable_latch) begin
                    next_last_rej = 1'b1;
                end else if (in_protected) begin
                    next_last_prot = 1'b1;
                end else begin
                    next_wip = 1'b1;
                    next_timer = `TIMER_W'(WRITE_CYCLE_CYCLES);
                    next_waddr = addr[16:0];
                    next_wdata = data0;
                    next_last_exec = 1'b1;
                end
            end else if (!paused && aligned) begin
                if (phase == PH_WAIT && !unknown && opcode == `CMD_WRITE_ENABLE) begin
                    next_wel = 1'b1;
                    next_last_exec = 1'b1;
                end else if (phase == PH_WAIT && !unknown && opcode == `CMD_WRITE_DISABLE) begin
                    next_wel = 1'b0;
                    next_last_exec = 1'b1;
                end else if (phase == PH_DATA && have_data && opcode == `CMD_STATUS_WRITE) begin
                    if (!write_enable_latch || hw_locked) begin
                        next_last_rej = 1'b1;
                    end else begin
                        next_wip = 1'b1;
                        next_timer = `TIMER_W'(WRITE_CYCLE_CYCLES);
                        next_pend_sr = 1'b1;
                        next_pend_bp = data0[`SR_BLOCK_HI:`SR_BLOCK_LO];
                        next_pend_wdis = data0[`SR_WRITE_DISABLE];
                        next_last_exec = 1'b1;
                    end
                end else if (phase == PH_DATA && have_data && opcode == `CMD_IDENT_PAGE_WRITE) begin
                    if (!write_enable_latch) begin
                        next_last_rej = 1'b1;
                    end else begin
                        next_wip = 1'b1;
                        next_timer = `TIMER_W'(WRITE_CYCLE_CYCLES);
                        next_last_exec = 1'b1;
                    end
                end
            end
            // drop the command, keep latch and busy flag
            next_sel = 1'b0;
            next_paused = 1'b0;
            next_started = 1'b0;
            next_have_data = 1'b0;
            next_unknown = 1'b0;
            next_phase = PH_OPCODE;
            next_bit_cnt = 3'h0;
            next_addr_cnt = 2'h0;
        end else begin
            // pause entry and exit with the serial clock low
            if (!paused && hold_fall && !sck) begin
                next_paused = 1'b1;
            end else if (paused && hold_rise && !sck) begin
                next_paused = 1'b0;
            end
            if (sck_rise) begin
                next_shift_in = byte_in;
                next_bit_cnt = bit_cnt + 3'h1; // position survives a pause
                if (bit_cnt == `BIT_LAST) begin
                    unique case (phase)
                        PH_OPCODE: begin
                            next_opcode = byte_in;
                            next_phase = PH_WAIT;
                            if (byte_in == `CMD_STATUS_READ) begin
                                next_phase = PH_READOUT;
                                next_out_sh = status_byte;
                            end else if (write_in_progress) begin
                                next_unknown = 1'b1;
                            end else if (byte_in == `CMD_WRITE_ENABLE || byte_in == `CMD_WRITE_DISABLE) begin
                                next_phase = PH_WAIT;
                            end else if (byte_in == `CMD_STATUS_WRITE) begin
                                next_phase = PH_DATA;
                            end else if (byte_in == `CMD_MEM_READ || byte_in == `CMD_MEM_WRITE) begin
                                next_phase = PH_ADDR;
                            end else if (ident_en && (byte_in == `CMD_IDENT_PAGE_READ
                                    || byte_in == `CMD_IDENT_PAGE_WRITE)) begin
                                next_phase = PH_ADDR;
                            end else begin
                                next_unknown = 1'b1;
                            end
                        end
                        PH_ADDR: begin
                            next_addr = {addr[15:0], byte_in};
                            next_addr_cnt = addr_cnt + 2'h1;
                            if (addr_cnt == `ADDR_LAST) begin
                                next_phase = is_read ? PH_READOUT : PH_DATA;
                                next_out_sh = read_fill;
                            end
                        end
                        PH_DATA: begin
                            if (!have_data) begin
                                next_data0 = byte_in;
                            end
                            next_have_data = 1'b1;
                        end
                        PH_READOUT: begin
                            next_out_sh = (opcode == `CMD_STATUS_READ) ? status_byte : read_fill;
                        end
                        PH_WAIT: begin
                            next_phase = PH_WAIT;
                        end
                        default: begin
                            next_phase = PH_WAIT;
                        end
                    endcase
                end
            end
            // output bits change after the falling edge
            if (sck_fall && phase == PH_READOUT) begin
                next_miso = out_sh[7];
                next_out_sh = {out_sh[6:0], 1'b0};
                next_started = 1'b1;
            end
        end
        next_miso_oe = next_sel && next_started && !next_paused && next_phase == PH_READOUT;
        next_standby = !next_sel && !next_wip;
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            cs_d <= 1'b1;
            hold_d <= 1'b1;
            sck_d <= 1'b0;
            sel <= 1'b0;
            armed <= 1'b0;
            paused <= 1'b0;
            started <= 1'b0;
            have_data <= 1'b0;
            unknown <= 1'b0;
            phase <= PH_OPCODE;
            bit_cnt <= 3'h0;
            addr_cnt <= 2'h0;
            shift_in <= 8'h00;
            opcode <= 8'h00;
            data0 <= 8'h00;
            out_sh <= 8'h00;
            addr <= 24'h000000;
            write_enable_latch <= 1'b0;
            write_in_progress <= 1'b0;
            wdis <= 1'b0;
            bp <= `BP_NONE;
            pend_sr <= 1'b0;
            pend_bp <= `BP_NONE;
            pend_wdis <= 1'b0;
            timer <= '0;
            last_op <= 8'h00;
            last_exec <= 1'b0;
            last_rej <= 1'b0;
            last_prot <= 1'b0;
            waddr <= 17'h00000;
            wdata <= 8'h00;
            MISO_LINE <= 1'b0;
            MISO_LINE_OE <= 1'b0;
            STANDBY <= 1'b1;
        end else begin
            cs_d <= cs_n;
            hold_d <= hold_n;
            sck_d <= sck;
            sel <= next_sel;
            armed <= next_armed;
            paused <= next_paused;
            started <= next_started;
            have_data <= next_have_data;
            unknown <= next_unknown;
            phase <= next_phase;
            bit_cnt <= next_bit_cnt;
            addr_cnt <= next_addr_cnt;
            shift_in <= next_shift_in;
            opcode <= next_opcode;
            data0 <= next_data0;
            out_sh <= next_out_sh;
            addr <= next_addr;
            write_enable_latch <= next_wel;
            write_in_progress <= next_wip;
            wdis <= next_wdis;
            bp <= next_bp;
            pend_sr <= next_pend_sr;
            pend_bp <= next_pend_bp;
            pend_wdis <= next_pend_wdis;
            timer <= next_timer;
            last_op <= next_last_op;
            last_exec <= next_last_exec;
            last_rej <= next_last_rej;
            last_prot <= next_last_prot;
            waddr <= next_waddr;
            wdata <= next_wdata;
            MISO_LINE <= next_miso;
            MISO_LINE_OE <= next_miso_oe;
            STANDBY <= next_standby;
        end
    end

    // avalon slave: one wait cycle, then answer
    logic next_ident_en, next_waitrequest;
    logic [7:0] next_read_fill;
    logic [31:0] next_readdata;

    always_comb begin
        next_ident_en = ident_en;
        next_read_fill = read_fill;
        next_readdata = READDATA;
        next_waitrequest = 1'b1;
        if ((READ || WRITE) && WAITREQUEST) begin
            next_waitrequest = 1'b0;
            // writes leave the last read data standing
            if (READ) begin
                unique case (ADDRESS)
                    `REG_STATUS: next_readdata = {21'h000000, unknown, paused, sel, status_byte};
                    `REG_CTRL: next_readdata = {16'h0000, read_fill, 7'h00, ident_en};
                    `REG_LAST: next_readdata = {21'h000000, last_prot, last_rej, last_exec, last_op};
                    `REG_WRITTEN: next_readdata = {wdata, 7'h00, waddr};
                    default: next_readdata = 32'h00000000;
                endcase
            end
        end
        if (WRITE && !WAITREQUEST && ADDRESS == `REG_CTRL) begin
            if (BYTEENABLE[0]) begin
                next_ident_en = WRITEDATA[0];
            end
            if (BYTEENABLE[1]) begin
                next_read_fill = WRITEDATA[15:8];
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ident_en <= 1'b0;
            read_fill <= 8'hff;
            READDATA <= 32'h00000000;
            WAITREQUEST <= 1'b1;
        end else begin
            ident_en <= next_ident_en;
            read_fill <= next_read_fill;
            READDATA <= next_readdata;
            WAITREQUEST <= next_waitrequest;
        end
    end
endmodule // eeprom_cmd_ctrl

// ==== verification/eeprom_cmd_ctrl_sva.sv ====
// port assertions for the serial eeprom command controller
`timescale 1ns/1ns
module eeprom_cmd_ctrl_sva (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic PICK_N,
    input wire logic SCK,
    input wire logic PAUSE_N,
    input wire logic MISO_LINE,
    input wire logic MISO_LINE_OE,
    input wire logic STANDBY,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] READDATA,
    input wire logic WAITREQUEST
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    // bus answer timing
    a_ack_one_cycle: assert property ($rose(READ || WRITE) |=> !WAITREQUEST)
        else $error("answer not one cycle after request");
    a_ack_single: assert property (!WAITREQUEST |=> WAITREQUEST)
        else $error("waitrequest low too long");
    a_ack_has_req: assert property ($fell(WAITREQUEST) |-> $past(READ) || $past(WRITE))
        else $error("answer without request");
    a_readdata_hold: assert property (!READ |=> $stable(READDATA))
        else $error("read data moved without read");
    // serial side
    a_float_deselect: assert property (PICK_N [*5] |-> !MISO_LINE_OE)
        else $error("output driven while deselected");
    a_active_select: assert property (!PICK_N [*5] |-> !STANDBY)
        else $error("standby while selected");
    a_pause_float: assert property (($fell(PAUSE_N) && !SCK && !PICK_N) ##1 (!PAUSE_N && !PICK_N) [*4]
        |=> !MISO_LINE_OE) else $error("output driven while paused");
    a_miso_steady: assert property ($rose(SCK) && MISO_LINE_OE |=> $stable(MISO_LINE) [*3])
        else $error("output moved after clock rise");
    c_read: cover property (READ && !WAITREQUEST);
    c_output: cover property (MISO_LINE_OE && $fell(SCK));
    c_paused: cover property (!PAUSE_N && !PICK_N);
endmodule // eeprom_cmd_ctrl_sva
bind eeprom_cmd_ctrl eeprom_cmd_ctrl_sva chk (.CLOCK(CLOCK), .RSTN(RSTN), .PICK_N(PICK_N), .SCK(SCK),
    .PAUSE_N(PAUSE_N), .MISO_LINE(MISO_LINE), .MISO_LINE_OE(MISO_LINE_OE), .STANDBY(STANDBY), .READ(READ),
    .WRITE(WRITE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST));

// ==== verification/spi_master_model.sv ====
// serial bus master model: select, clock, data and pause lines
`timescale 1ns/1ns
module spi_master_model (
    output logic PICK_N,
    output logic SCK,
    output logic MOSI,
    output logic PAUSE_N,
    input wire logic MISO_LINE
);
    logic [7:0] got;
    // idle: deselected, clock parked low
    initial begin
        PICK_N = 1'b1;
        SCK = 1'b0;
        MOSI = 1'b0;
        PAUSE_N = 1'b1;
        got = 8'h0;
    end
    task automatic sel();
        PICK_N = 1'b0;
        #60;
    endtask
    // rise after the final falling edge, no further clock rise
    task automatic desel();
        #20;
        PICK_N = 1'b1;
        #60;
    endtask
    // top n bits, msb first, 125 ns per bit; output sampled at each rise
    task automatic shift(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            MOSI = b[7 - i];
            #62;
            SCK = 1'b1;
            got = {got[6:0], MISO_LINE};
            #63;
            SCK = 1'b0;
        end
        MOSI = ~MOSI;
    endtask
    // only called with the clock low; mwr and the main sequence also release it after deselect
    task automatic pause(input logic on);
        PAUSE_N = !on;
        #60;
    endtask
endmodule // spi_master_model

// ==== verification/serial_eeprom_command_control_test.sv ====
// self-checking bench for the serial eeprom command controller
`timescale 1ns/1ns
`include "eeprom_regs.svh"
module serial_eeprom_command_control_test;
    localparam int CYC = 20;
    logic CLOCK, RSTN, PROTECT_PIN_N, READ, WRITE, WAITREQUEST, MISO_LINE, MISO_LINE_OE, STANDBY, pr;
    logic PICK_N, SCK, MOSI, PAUSE_N;
    logic [3:0] ADDRESS, BYTEENABLE, be;
    logic [31:0] WRITEDATA, READDATA, rnd, ctl;
    logic [7:0] sr;
    logic [31:0] expq[$];
    logic [16:0] adr [4] = '{17'h0ffff, 17'h10000, 17'h17fff, 17'h18000};
    logic [9:0] ops [5] = '{10'h0ff, 10'h082, 10'h382, 10'h383, 10'h203};
    int failures, comparisons;
    wire miso_wire = MISO_LINE_OE ? MISO_LINE : ~MISO_LINE;
    spi_master_model m (.PICK_N(PICK_N), .SCK(SCK), .MOSI(MOSI), .PAUSE_N(PAUSE_N), .MISO_LINE(miso_wire));
    eeprom_cmd_ctrl #(.WRITE_CYCLE_CYCLES(CYC)) dut (.CLOCK(CLOCK), .RSTN(RSTN), .PICK_N(PICK_N), .SCK(SCK),
        .MOSI(MOSI), .PAUSE_N(PAUSE_N), .PROTECT_PIN_N(PROTECT_PIN_N), .MISO_LINE(MISO_LINE),
        .MISO_LINE_OE(MISO_LINE_OE), .STANDBY(STANDBY), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
        .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // bus master: hold the request until waitrequest is sampled low
    task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge CLOCK);
        READ <= rd;
        WRITE <= !rd;
        ADDRESS <= a;
        WRITEDATA <= d;
        BYTEENABLE <= be;
        do begin
            @(posedge CLOCK);
            n++;
        end while (WAITREQUEST !== 1'b0 && n < 50);
        READ <= 1'b0;
        WRITE <= 1'b0;
        if (WAITREQUEST !== 1'b0) begin
            failures++;
            test_done();
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        expq.push_back(e);
        xfer(1'b1, a, 32'h0);
    endtask
    task automatic st(input logic [31:0] e);
        rd(`REG_STATUS, e);
    endtask
    task automatic cmd(input logic [7:0] op);
        m.sel();
        m.shift(op, 8);
        m.desel();
    endtask
    task automatic mwr(input logic [16:0] a, input logic [7:0] d, input logic hold);
        m.sel();
        m.shift(`CMD_MEM_WRITE, 8);
        m.shift({7'h0, a[16]}, 8);
        m.shift(a[15:8], 8);
        m.shift(a[7:0], 8);
        m.shift(d, 8);
        if (hold) m.pause(1'b1);
        m.desel();
        m.pause(1'b0);
    endtask
    task automatic cmd_status_write(input logic [7:0] d, input int n);
        cmd(`CMD_WRITE_ENABLE);
        m.sel();
        m.shift(`CMD_STATUS_WRITE, 8);
        m.shift(d, n);
        m.desel();
    endtask
    // compare each read answer with the oldest expectation
    always @(posedge CLOCK) begin
        if (READ === 1'b1 && WAITREQUEST === 1'b0) check(READDATA, expq.pop_front());
    end
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    // main sequence
    initial begin
        {RSTN, READ, WRITE, ADDRESS, WRITEDATA, BYTEENABLE, sr, failures, comparisons} = '0;
        be = 4'hf;
        ctl = 32'h0000ff00;
        PROTECT_PIN_N = 1'b1;
        rnd = 32'd86670;
        repeat (5) @(posedge CLOCK);
        RSTN <= 1'b1;
        st(32'h0);
        rd(`REG_CTRL, 32'h0000ff00);
        rd(4'h2, 32'h0);
        for (int i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            be = rnd[19:16];
            xfer(1'b0, `REG_CTRL, rnd);
            // only enabled lanes take the new value
            ctl = {16'h0, be[1] ? rnd[15:8] : ctl[15:8], 7'h0, be[0] ? rnd[0] : ctl[0]};
            rd(`REG_CTRL, ctl);
        end
        be = 4'hf;
        xfer(1'b0, `REG_CTRL, 32'h0);
        cmd(`CMD_WRITE_ENABLE);
        st(32'h2);
        rd(`REG_LAST, 32'h106);
        m.sel();
        m.shift(`CMD_STATUS_READ, 8);
        m.shift(8'h0, 8);
        m.pause(1'b1);
        check({31'h0, MISO_LINE_OE}, 32'h0);
        m.pause(1'b0);
        check({31'h0, MISO_LINE_OE}, 32'h1);
        check({24'h0, m.got}, 32'h2);
        m.desel();
        cmd(`CMD_WRITE_DISABLE);
        st(32'h0);
        mwr(17'h0, 8'h5a, 1'b0);
        rd(`REG_LAST, 32'h202);
        cmd_status_write(8'h0c, 7);
        st(32'h2);
        // every protect code against addresses on both sides of each boundary
        for (int bp = 0; bp < 4; bp++) begin
            // old protect bits stand until the write cycle ends
            cmd_status_write({4'h0, bp[1:0], 2'h0}, 8);
            st({24'h0, sr | 8'h03});
            check({31'h0, STANDBY}, 32'h0);
            sr = {4'h0, bp[1:0], 2'h0};
            repeat (CYC + 10) @(posedge CLOCK);
            check({31'h0, STANDBY}, 32'h1);
            st({24'h0, sr});
            foreach (adr[j]) begin
                rnd = lfsr(rnd);
                PROTECT_PIN_N <= rnd[9];
                cmd(`CMD_WRITE_ENABLE);
                mwr(adr[j], rnd[7:0], j == 0);
                pr = bp == 3 || (bp == 2 && adr[j] >= 17'h10000) || (bp == 1 && adr[j] >= 17'h18000);
                rd(`REG_LAST, pr ? 32'h402 : 32'h102);
                if (!pr) rd(`REG_WRITTEN, {rnd[7:0], 7'h0, adr[j]});
                repeat (CYC + 10) @(posedge CLOCK);
            end
        end
        cmd_status_write(8'h8c, 8);
        repeat (CYC + 10) @(posedge CLOCK);
        PROTECT_PIN_N <= 1'b0;
        cmd_status_write(8'h00, 8);
        st(32'h8e);
        PROTECT_PIN_N <= 1'b1;
        cmd_status_write(8'h00, 8);
        repeat (CYC + 10) @(posedge CLOCK);
        st(32'h0);
        // unknown codes wait; ident codes only known when enabled
        foreach (ops[k]) begin
            xfer(1'b0, `REG_CTRL, {31'h0, ops[k][8]});
            m.sel();
            m.shift(ops[k][7:0], 8);
            st({21'h0, !ops[k][9], 10'h100});
            m.desel();
        end
        // pause mid-byte, junk clocks while paused, then resume
        m.sel();
        m.shift(`CMD_WRITE_ENABLE, 4);
        m.pause(1'b1);
        st(32'h300);
        m.shift(8'hff, 3);
        m.pause(1'b0);
        m.shift(8'h60, 4);
        m.desel();
        st(32'h2);
        m.sel();
        m.shift(`CMD_WRITE_DISABLE, 8);
        m.pause(1'b1);
        m.desel();
        m.pause(1'b0);
        st(32'h2);
        test_done();
    end
endmodule // serial_eeprom_command_control_test
